// File: verilog/enc_sim_pkg.sv
// Notes on behaviour
// - With exponent mode off the pulses-per-revolution setting is a direct count from 4 to 65535.
// - With exponent mode on the setting is an exponent n, giving 2^n pulses per revolution, n at most 18.
// - The pulses-per-revolution setting resets to 1024.
// - A source-select flag picks the motor shaft position or the pointed parameter as the source.
// - The motor shaft position is always read at full resolution, 2^20 counts per revolution.
// - With position-loop scaling off, a pointed value is taken as a fraction of a revolution at its own lower resolution, not rescaled.
// - A zero marker pulse is generated on trace C besides the two incremental channels.
// - The simulated output frequency never exceeds 400 kHz.
// - With position-loop scaling on, the output is built from values at position-loop resolution.
// - The same pulse train appears on two output connectors at once.
package enc_sim_pkg;

   // clock and output rate limits
   localparam int CLK_HZ          = 50_000_000;
   localparam int MAX_OUT_HZ      = 400_000;
   localparam int EDGES_PER_PULSE = 4;
   localparam int EDGE_GAP        = (CLK_HZ + MAX_OUT_HZ * EDGES_PER_PULSE - 1)
                                    / (MAX_OUT_HZ * EDGES_PER_PULSE);

   // position widths
   localparam int POS_BITS = 20;
   localparam int CNT_W    = 21;

   // pulses-per-revolution and resolution limits and reset values
   localparam logic [15:0] PPR_MIN   = 16'h0004;
   localparam logic [15:0] EXP_MAX   = 16'h0012;
   localparam logic [15:0] PPR_RESET = 16'h0400;
   localparam logic [4:0]  RES_RESET = 5'h10;
   localparam logic [4:0]  RES_FULL  = 5'h14;
   localparam logic [4:0]  RES_MIN   = 5'h01;

   // register byte offsets
   localparam logic [11:0] OFF_PPR     = 12'h000;
   localparam logic [11:0] OFF_CTRL    = 12'h004;
   localparam logic [11:0] OFF_POINTER = 12'h008;
   localparam logic [11:0] OFF_RES     = 12'h00c;
   localparam logic [11:0] OFF_COUNT   = 12'h010;
   localparam logic [11:0] OFF_MODULUS = 12'h014;

   // control register fields
   localparam int CTRL_EXP_BIT   = 0;
   localparam int CTRL_SRC_BIT   = 3;
   localparam int CTRL_SCALE_BIT = 8;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // quadrature edges per revolution from the setting
   function automatic logic [CNT_W-1:0] edges_per_rev(
      input logic [15:0] setting,
      input logic        exp_mode);
      logic [4:0]  n;
      logic [15:0] p;
      n = (setting > EXP_MAX) ? EXP_MAX[4:0] : setting[4:0];
      p = (setting < PPR_MIN) ? PPR_MIN : setting;
      if (exp_mode) begin
         edges_per_rev = {{(CNT_W-1){1'b0}}, 1'b1} << (n + 5'h2);
      end else begin
         edges_per_rev = {3'h0, p, 2'h0};
      end
   endfunction : edges_per_rev

endpackage : enc_sim_pkg

// File: verilog/enc_motion_if.sv
`timescale 1ns/1ns
`default_nettype none
// target position and modulus, both in quadrature edges
interface enc_motion_if;
   logic [enc_sim_pkg::CNT_W-1:0] target;
   logic [enc_sim_pkg::CNT_W-1:0] modulus;
   modport src  (output target, output modulus);
   modport sink (input target, input modulus);
endinterface : enc_motion_if
`default_nettype wire

// File: verilog/enc_scaler.sv
`timescale 1ns/1ns
`default_nettype none
module enc_scaler (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic [19:0] motor_position,
   input  wire logic [19:0] pointed_value,
   input  wire logic [4:0]  res_bits,
   input  wire logic        src_sel,
   input  wire logic        exp_mode,
   input  wire logic        scale,
   input  wire logic [15:0] ppr,
   enc_motion_if.src        mo
);
   typedef struct packed {
      logic [enc_sim_pkg::CNT_W-1:0] target;
      logic [enc_sim_pkg::CNT_W-1:0] modulus;
   } scaler_s;

   scaler_s q;
   scaler_s next_q;

   // map the source fraction onto the edge count of one revolution
   always_comb begin
      logic [4:0]  bits;
      logic [19:0] frac;
      logic [40:0] prod;
      bits   = enc_sim_pkg::RES_FULL;
      frac   = motor_position;
      prod   = '0;
      next_q = q;
      next_q.modulus = enc_sim_pkg::edges_per_rev(ppr, exp_mode);
      if (src_sel) begin
         if (scale) begin
            frac = pointed_value;
         end else begin
            // own resolution, no rescale to full
            bits = (res_bits > enc_sim_pkg::RES_FULL) ? enc_sim_pkg::RES_FULL
                 : (res_bits < enc_sim_pkg::RES_MIN) ? enc_sim_pkg::RES_MIN
                 : res_bits;
            frac = pointed_value & ~(20'hfffff << bits);
         end
      end
      prod = {21'h0, frac} * {20'h0, next_q.modulus};
      next_q.target = 21'(prod >> bits);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign mo.target  = q.target;
   assign mo.modulus = q.modulus;
endmodule : enc_scaler
`default_nettype wire

// File: verilog/enc_stepper.sv
`timescale 1ns/1ns
`default_nettype none
module enc_stepper #(
   parameter int GAP = enc_sim_pkg::EDGE_GAP
) (
   input  wire logic                          mclk,
   input  wire logic                          rst_b,
   enc_motion_if.sink                         mi,
   output logic                               chan_a,
   output logic                               chan_b,
   output logic                               chan_z,
   output logic [enc_sim_pkg::CNT_W-1:0]      count
);
   localparam int GW = $clog2(GAP + 1);
   localparam int MIN_AGE = GAP - 1;

   // the age helper saturates at 255, so wider gaps cannot be checked
   if (GAP < 1 || GAP > 255) begin : g_bad_gap
      $error("edge gap must be 1 to 255 cycles");
   end

   typedef struct packed {
      logic [enc_sim_pkg::CNT_W-1:0] count;
      logic [GW-1:0]                 gap;
      logic                          a;
      logic                          b;
      logic                          z;
   } step_s;

   step_s q;
   step_s next_q;

   // walk one edge at a time toward the target, shortest way round
   always_comb begin
      logic [enc_sim_pkg::CNT_W-1:0] fwd;
      fwd    = '0;
      next_q = q;
      if (q.count >= mi.modulus) begin
         // modulus shrank under us: restart at zero
         next_q.count = '0;
      end else if (q.gap != '0) begin
         next_q.gap = q.gap - 1'b1;
      end else if (q.count != mi.target) begin
         fwd = (mi.target >= q.count) ? mi.target - q.count
             : mi.target + mi.modulus - q.count;
         if (fwd <= (mi.modulus >> 1)) begin
            next_q.count = (q.count == mi.modulus - 1'b1) ? '0
                         : q.count + 1'b1;
         end else begin
            next_q.count = (q.count == '0) ? mi.modulus - 1'b1
                         : q.count - 1'b1;
         end
         next_q.gap = GW'(GAP - 1);
      end
      // gray sequence: a leads b going forward
      next_q.a = next_q.count[0] ^ next_q.count[1];
      next_q.b = next_q.count[1];
      next_q.z = (next_q.count == '0);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '{count: '0, gap: '0, a: 1'b0, b: 1'b0, z: 1'b1};
      end else begin
         q <= next_q;
      end
   end

   assign chan_a = q.a;
   assign chan_b = q.b;
   assign chan_z = q.z;
   assign count  = q.count;

   // helper: cycles since the last edge
   logic [7:0] age;
   logic       stepped;
   logic       in_range;
   assign in_range = (q.count < mi.modulus);
   assign stepped  = (next_q.count != q.count) && in_range;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         age <= 8'hff;
      end else begin
         age <= stepped ? 8'h00 : ((age == 8'hff) ? age : age + 8'h01);
      end
   end

   property p_rate_cap;
      @(posedge mclk) disable iff (!rst_b)
      stepped |-> age >= MIN_AGE;
   endproperty
   a_rate_cap: assert property (p_rate_cap)
      else $error("edges closer than the rate cap allows");

   property p_quadrature;
      @(posedge mclk) disable iff (!rst_b)
      ($changed(q.a) || $changed(q.b)) && $past(in_range)
      |-> $changed(q.a) != $changed(q.b);
   endproperty
   a_quadrature: assert property (p_quadrature)
      else $error("both channels toggled at once");

   property p_marker;
      @(posedge mclk) disable iff (!rst_b)
      $rose(q.z) |-> (q.count == '0) && !q.a && !q.b;
   endproperty
   a_marker: assert property (p_marker)
      else $error("marker raised away from zero");
endmodule : enc_stepper
`default_nettype wire

// File: verilog/enc_pulse_sim.sv
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module enc_pulse_sim (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // register bus
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // position sources
   input  wire logic [19:0] motor_position,
   input  wire logic [19:0] pointed_value,
   output logic [15:0]      sim_source_pointer,
   // two connectors
   output logic             enc_a0,
   output logic             enc_b0,
   output logic             enc_c0,
   output logic             enc_a1,
   output logic             enc_b1,
   output logic             enc_c1
);
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        aw_hold;
      logic [11:0] awaddr;
      logic        w_hold;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic [15:0] sim_pulses_per_rev;
      logic        ppr_exponent_mode;
      logic        sim_source_select;
      logic        sim_position_loop_scaling;
      logic [15:0] pointer;
      logic [4:0]  res_bits;
      logic [5:0]  enc;
      logic        armed;
   } top_s;

   top_s q;
   top_s next_q;

   enc_motion_if mif ();

   logic                          st_a;
   logic                          st_b;
   logic                          st_z;
   logic [enc_sim_pkg::CNT_W-1:0] st_count;

   enc_scaler u_scaler (
      .mclk           (mclk),
      .rst_b          (rst_b),
      .motor_position (motor_position),
      .pointed_value  (pointed_value),
      .res_bits       (q.res_bits),
      .src_sel        (q.sim_source_select),
      .exp_mode       (q.ppr_exponent_mode),
      .scale          (q.sim_position_loop_scaling),
      .ppr            (q.sim_pulses_per_rev),
      .mo             (mif)
   );

   enc_stepper u_stepper (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .mi     (mif),
      .chan_a (st_a),
      .chan_b (st_b),
      .chan_z (st_z),
      .count  (st_count)
   );

   // merge written byte lanes into a register value
   function automatic logic [31:0] merge_be(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0]  be);
      merge_be = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge_be[8*i +: 8] = wd[8*i +: 8];
         end
      end
   endfunction : merge_be

   // control word as seen on the bus
   function automatic logic [31:0] ctrl_word(input top_s s);
      ctrl_word = 32'h0;
      ctrl_word[enc_sim_pkg::CTRL_EXP_BIT]   = s.ppr_exponent_mode;
      ctrl_word[enc_sim_pkg::CTRL_SRC_BIT]   = s.sim_source_select;
      ctrl_word[enc_sim_pkg::CTRL_SCALE_BIT] = s.sim_position_loop_scaling;
   endfunction : ctrl_word

   // bus slave, register file and output copies
   always_comb begin
      logic [31:0] v;
      v      = 32'h0;
      next_q = q;
      if (q.bvalid && s_axi_bready) begin
         next_q.bvalid = 1'b0;
      end
      if (q.rvalid && s_axi_rready) begin
         next_q.rvalid = 1'b0;
      end
      // address and data may come in either order
      if (q.awready && s_axi_awvalid) begin
         next_q.aw_hold = 1'b1;
         next_q.awaddr  = s_axi_awaddr;
      end
      if (q.wready && s_axi_wvalid) begin
         next_q.w_hold = 1'b1;
         next_q.wdata  = s_axi_wdata;
         next_q.wstrb  = s_axi_wstrb;
      end
      if (q.aw_hold && q.w_hold && !q.bvalid) begin
         next_q.aw_hold = 1'b0;
         next_q.w_hold  = 1'b0;
         next_q.bvalid  = 1'b1;
         next_q.bresp   = enc_sim_pkg::RESP_OKAY;
         case (q.awaddr)
            enc_sim_pkg::OFF_PPR: begin
               v = merge_be({16'h0, q.sim_pulses_per_rev}, q.wdata, q.wstrb);
               next_q.sim_pulses_per_rev = v[15:0];
            end
            enc_sim_pkg::OFF_CTRL: begin
               v = merge_be(ctrl_word(q), q.wdata, q.wstrb);
               next_q.ppr_exponent_mode = v[enc_sim_pkg::CTRL_EXP_BIT];
               next_q.sim_source_select = v[enc_sim_pkg::CTRL_SRC_BIT];
               next_q.sim_position_loop_scaling =
                  v[enc_sim_pkg::CTRL_SCALE_BIT];
            end
            enc_sim_pkg::OFF_POINTER: begin
               v = merge_be({16'h0, q.pointer}, q.wdata, q.wstrb);
               next_q.pointer = v[15:0];
            end
            enc_sim_pkg::OFF_RES: begin
               v = merge_be({27'h0, q.res_bits}, q.wdata, q.wstrb);
               next_q.res_bits = v[4:0];
            end
            // read-only words swallow writes quietly
            enc_sim_pkg::OFF_COUNT, enc_sim_pkg::OFF_MODULUS: begin
               next_q.bresp = enc_sim_pkg::RESP_OKAY;
            end
            default: begin
               next_q.bresp = enc_sim_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (q.arready && s_axi_arvalid) begin
         next_q.rvalid = 1'b1;
         next_q.rresp  = enc_sim_pkg::RESP_OKAY;
         case (s_axi_araddr)
            enc_sim_pkg::OFF_PPR:
               next_q.rdata = {16'h0, q.sim_pulses_per_rev};
            enc_sim_pkg::OFF_CTRL:    next_q.rdata = ctrl_word(q);
            enc_sim_pkg::OFF_POINTER: next_q.rdata = {16'h0, q.pointer};
            enc_sim_pkg::OFF_RES:     next_q.rdata = {27'h0, q.res_bits};
            enc_sim_pkg::OFF_COUNT:   next_q.rdata = {11'h0, st_count};
            enc_sim_pkg::OFF_MODULUS: next_q.rdata = {11'h0, mif.modulus};
            default: begin
               next_q.rdata = 32'h0;
               next_q.rresp = enc_sim_pkg::RESP_SLVERR;
            end
         endcase
      end
      // one write and one read in flight at most
      next_q.awready = !next_q.aw_hold && !next_q.bvalid;
      next_q.wready  = !next_q.w_hold && !next_q.bvalid;
      next_q.arready = !next_q.rvalid;
      // same train on both connectors
      next_q.enc = {st_z, st_b, st_a, st_z, st_b, st_a};
      // checks wait one edge: release at a clock edge leaves stale pipes
      next_q.armed = 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.sim_pulses_per_rev <= enc_sim_pkg::PPR_RESET;
         q.res_bits           <= enc_sim_pkg::RES_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign s_axi_awready      = q.awready;
   assign s_axi_wready       = q.wready;
   assign s_axi_bvalid       = q.bvalid;
   assign s_axi_bresp        = q.bresp;
   assign s_axi_arready      = q.arready;
   assign s_axi_rvalid       = q.rvalid;
   assign s_axi_rresp        = q.rresp;
   assign s_axi_rdata        = q.rdata;
   assign sim_source_pointer = q.pointer;
   assign {enc_c1, enc_b1, enc_a1, enc_c0, enc_b0, enc_a0} = q.enc;

   // helper: expected target from the motor shaft
   logic [40:0] expect_motor;
   assign expect_motor = {21'h0, motor_position}
      * {20'h0, enc_sim_pkg::edges_per_rev(q.sim_pulses_per_rev,
                                           q.ppr_exponent_mode)};

   property p_ppr_reset;
      @(posedge mclk) disable iff (!rst_b)
      $rose(rst_b) |-> q.sim_pulses_per_rev == 16'h0400;
   endproperty
   a_ppr_reset: assert property (p_ppr_reset)
      else $error("pulses per revolution not at its reset value");

   property p_linear;
      @(posedge mclk) disable iff (!q.armed)
      (!q.ppr_exponent_mode && q.sim_pulses_per_rev >= 16'h0004)
      |=> mif.modulus == {3'h0, $past(q.sim_pulses_per_rev), 2'h0};
   endproperty
   a_linear: assert property (p_linear)
      else $error("direct count not honoured");

   property p_exponent;
      @(posedge mclk) disable iff (!rst_b)
      (q.ppr_exponent_mode && q.sim_pulses_per_rev <= 16'h0012)
      |=> mif.modulus == (21'h4 << $past(q.sim_pulses_per_rev[4:0]));
   endproperty
   a_exponent: assert property (p_exponent)
      else $error("exponent setting not honoured");

   property p_exp_cap;
      @(posedge mclk) disable iff (!rst_b)
      q.ppr_exponent_mode |=> mif.modulus <= 21'h100000;
   endproperty
   a_exp_cap: assert property (p_exp_cap)
      else $error("exponent above the cap");

   property p_motor_full;
      @(posedge mclk) disable iff (!q.armed)
      !q.sim_source_select |=> mif.target == $past(expect_motor[40:20]);
   endproperty
   a_motor_full: assert property (p_motor_full)
      else $error("motor position not read at full resolution");

   property p_pointed_own;
      @(posedge mclk) disable iff (!rst_b)
      (q.sim_source_select && !q.sim_position_loop_scaling
       && q.res_bits == 5'h10 && pointed_value[15:0] == 16'h8000)
      |=> mif.target == {1'b0, mif.modulus[20:1]};
   endproperty
   a_pointed_own: assert property (p_pointed_own)
      else $error("pointed value rescaled");

   property p_loop_scaled;
      @(posedge mclk) disable iff (!rst_b)
      (q.sim_source_select && q.sim_position_loop_scaling
       && pointed_value == 20'h80000)
      |=> mif.target == {1'b0, mif.modulus[20:1]};
   endproperty
   a_loop_scaled: assert property (p_loop_scaled)
      else $error("loop-scaled value misread");

   property p_twin;
      @(posedge mclk) disable iff (!q.armed)
      ##1 (enc_a0 == enc_a1) && (enc_b0 == enc_b1) && (enc_c0 == enc_c1)
          && (enc_a0 == $past(st_a)) && (enc_c0 == $past(st_z));
   endproperty
   a_twin: assert property (p_twin)
      else $error("connectors disagree");
endmodule : enc_pulse_sim
`default_nettype wire

// File: testbench/enc_counter_model.sv
`timescale 1ns/1ns
`default_nettype none
// downstream quadrature counter fed by both connectors
module enc_counter_model (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic a0,
   input  wire logic b0,
   input  wire logic c0,
   input  wire logic a1,
   input  wire logic b1,
   input  wire logic c1,
   output var int    pos,
   output var int    markers,
   output var int    bad
);
   logic [1:0] prev;
   logic       prev_c;
   int         gap;
   wire  [1:0] idx = {b0, a0 ^ b0};

   // gray index 0..3 in forward order; a skipped state is a fault
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pos <= 0;
         markers <= 0;
         bad <= 0;
         prev <= 2'h0;
         prev_c <= 1'b0;
         gap <= enc_sim_pkg::EDGE_GAP;
      end else begin
         if ({a0, b0, c0} !== {a1, b1, c1}) bad <= bad + 1;
         if (c0 && idx != 2'h0) bad <= bad + 1;
         if (c0 && !prev_c) markers <= markers + 1;
         if (idx != prev) begin
            // gap counts quiet edges between changes, one gap apart
            if (gap < enc_sim_pkg::EDGE_GAP - 1) bad <= bad + 1;
            case (2'(idx - prev))
               2'h1: pos <= pos + 1;
               2'h3: pos <= pos - 1;
               default: bad <= bad + 1;
            endcase
            gap <= 0;
         end else begin
            gap <= gap + 1;
         end
         prev <= idx;
         prev_c <= c0;
      end
   end
endmodule : enc_counter_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [19:0] motor_position = 20'h0, pointed_value = 20'h0;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata, v;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [15:0] pointer;
   logic        a0, b0, c0, a1, b1, c1;
   int          pos, markers, bad, m;
   int          fail_count = 0, compares = 0, cycles = 0;
   logic [31:0] t_ctrl [6] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h1, 32'h0};
   logic [31:0] t_ppr  [6] = '{32'h3, 32'hffff, 32'h12, 32'h14, 32'h2, 32'h4};
   logic [31:0] t_mod  [6] = '{32'h10, 32'h3fffc, 32'h100000, 32'h100000,
                               32'h10, 32'h10};

   enc_pulse_sim DUT (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .motor_position(motor_position), .pointed_value(pointed_value),
      .sim_source_pointer(pointer), .enc_a0(a0), .enc_b0(b0), .enc_c0(c0),
      .enc_a1(a1), .enc_b1(b1), .enc_c1(c1));

   enc_counter_model far_end (.mclk(mclk), .rst_b(rst_b), .a0(a0), .b0(b0),
      .c0(c0), .a1(a1), .b1(b1), .c1(c1), .pos(pos), .markers(markers),
      .bad(bad));

   always #10 mclk = ~mclk;

   // hang guard, well above the few thousand cycles the tests need
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // both write channels offered together, each released when taken
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axi_read

   // polls the edge position; the rate cap makes moves take a while
   task automatic wait_count(input logic [31:0] exp);
      v = 32'hffffffff;
      for (int i = 0; i < 300 && v !== exp; i++) begin
         axi_read(enc_sim_pkg::OFF_COUNT, v);
      end
      repeat (3) @(posedge mclk); // outputs and model trail the count
   endtask : wait_count

   task automatic close_out;
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      axi_read(enc_sim_pkg::OFF_PPR, v);
      check("ppr reset", v, 32'h400);
      axi_read(enc_sim_pkg::OFF_MODULUS, v);
      check("modulus reset", v, 32'h1000);
      axi_read(enc_sim_pkg::OFF_CTRL, v);
      check("ctrl reset", v, 32'h0);
      axi_read(12'h100, v);
      check("unmapped resp", {30'h0, r}, {30'h0, enc_sim_pkg::RESP_SLVERR});
      check("unmapped data", v, 32'h0);
      axi_write(enc_sim_pkg::OFF_POINTER, 32'h55);
      check("pointer", {16'h0, pointer}, 32'h55);
      // both ppr modes with their limits, taken at count zero
      for (int i = 0; i < 6; i++) begin
         axi_write(enc_sim_pkg::OFF_CTRL, t_ctrl[i]);
         axi_write(enc_sim_pkg::OFF_PPR, t_ppr[i]);
         axi_read(enc_sim_pkg::OFF_MODULUS, v);
         check("modulus", v, t_mod[i]);
      end
      axi_write(enc_sim_pkg::OFF_COUNT, 32'h5);
      check("count wr resp", {30'h0, r}, {30'h0, enc_sim_pkg::RESP_OKAY});
      axi_read(enc_sim_pkg::OFF_COUNT, v);
      check("count ro", v, 32'h0);
      // one turn forward in quarters, 65536 shaft counts per edge
      m = markers;
      for (int q = 1; q <= 4; q++) begin
         motor_position <= 20'(q * 32'h40000);
         wait_count(32'((4 * q) % 16));
         check("count fwd", v, 32'((4 * q) % 16));
      end
      check("model pos", 32'(pos), 32'h10);
      check("markers", 32'(markers - m), 32'h1);
      // one edge backwards takes the short way
      motor_position <= 20'hf0000;
      wait_count(32'hf);
      check("count back", v, 32'hf);
      check("model back", 32'(pos), 32'hf);
      motor_position <= 20'h0;
      wait_count(32'h0);
      // pointed source at 4-bit resolution: 8 of 16 is half a turn
      pointed_value <= 20'h8;
      axi_write(enc_sim_pkg::OFF_RES, 32'h4);
      axi_write(enc_sim_pkg::OFF_CTRL, 32'h8);
      wait_count(32'h8);
      check("pointed", v, 32'h8);
      // 16-bit resolution: half a turn is 0x8000
      pointed_value <= 20'h08000;
      axi_write(enc_sim_pkg::OFF_RES, 32'h10);
      wait_count(32'h8);
      check("pointed 16 bit", v, 32'h8);
      // loop scaling reads the same value at full resolution
      axi_write(enc_sim_pkg::OFF_CTRL, 32'h108);
      wait_count(32'h0);
      check("scaled small", v, 32'h0);
      pointed_value <= 20'h80000;
      wait_count(32'h8);
      check("scaled half", v, 32'h8);
      pointed_value <= 20'hc0000;
      wait_count(32'hc);
      check("scaled", v, 32'hc);
      check("model faults", 32'(bad), 32'h0);
      close_out();
   end
endmodule : tb
`default_nettype wire
